//--- rtl/ucgp_pkg.sv
////////////////////////////////////////////////////////////////////////////////
package ucgp_pkg;

   // port geometry: four channels of four pins each
   localparam int unsigned NUM_CHAN       = 4;
   localparam int unsigned PIN_PER_CHAN   = 4;

   // register offsets, per channel
   localparam logic [7:0]  ADDR_PIN_CONFIG = 8'h18;
   localparam logic [7:0]  ADDR_PIN_DATA   = 8'h19;

   // reset values
   localparam logic [7:0]  PIN_CONFIG_RST  = 8'h00;
   localparam logic [7:0]  PIN_DATA_RST    = 8'h00;
   localparam logic [3:0]  PULL_DN_RST     = 4'hf;
   localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;

   // field positions (each field is one nibble)
   localparam int unsigned CFG_DIR_LSB     = 0;
   localparam int unsigned CFG_OD_LSB      = 4;
   localparam int unsigned DATA_OUT_LSB    = 0;
   localparam int unsigned DATA_IN_LSB     = 4;
   localparam int unsigned CHAR_HI_LSB     = 4;

   // one bit per local pin of a channel
   typedef logic [3:0] ucgp_nib_t;

endpackage : ucgp_pkg

//--- rtl/ucgp_pin_if.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// control and sensed levels between the register file and one channel's pads
interface ucgp_pin_if;
   logic [3:0] pin_dir_is_output;
   logic [3:0] pin_drive_open_sel;
   logic [3:0] pin_drive_level;
   logic [3:0] pin_sensed_level;

   modport ctrl (
      output pin_dir_is_output,
      output pin_drive_open_sel,
      output pin_drive_level,
      input  pin_sensed_level
   );

   modport pad (
      input  pin_dir_is_output,
      input  pin_drive_open_sel,
      input  pin_drive_level,
      output pin_sensed_level
   );
endinterface : ucgp_pin_if

//--- rtl/ucgp_pad.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// pad control and input synchroniser for the four pins of one channel
module ucgp_pad (
   // clock and synchronised reset
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   // register side
   ucgp_pin_if.pad                pin_if,
   // pins
   input  wire ucgp_pkg::ucgp_nib_t pin_in_i,
   output      ucgp_pkg::ucgp_nib_t pin_out_o,
   output      ucgp_pkg::ucgp_nib_t pin_oe_o,
   output      ucgp_pkg::ucgp_nib_t pin_pull_dn_o
);
   import ucgp_pkg::*;

   ucgp_nib_t sync1_q;
   ucgp_nib_t sync1_d;
   ucgp_nib_t sync2_q;
   ucgp_nib_t sync2_d;
   ucgp_nib_t out_q;
   ucgp_nib_t out_d;
   ucgp_nib_t oe_q;
   ucgp_nib_t oe_d;
   ucgp_nib_t pd_q;
   ucgp_nib_t pd_d;

   ////////////////////////////////////////////////////////////////////////////
   // next pad state; open-drain only ever drives a low, so the level is held
   // at zero and the level bit steers the enable instead
   always_comb begin
      sync1_d = pin_in_i;
      sync2_d = sync1_q;
      out_d   = pin_if.pin_drive_level & ~pin_if.pin_drive_open_sel;
      // push-pull enables on direction; open-drain releases for a high,
      // which only reaches the pin through an external pull-up
      oe_d    = pin_if.pin_dir_is_output & (~pin_if.pin_drive_open_sel | ~pin_if.pin_drive_level);
      pd_d    = ~pin_if.pin_dir_is_output;
   end

   // everything moves on the reference clock; only the asynchronous reset acts without it
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         out_q   <= '0;
         oe_q    <= '0;
         pd_q    <= PULL_DN_RST;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         out_q   <= out_d;
         oe_q    <= oe_d;
         pd_q    <= pd_d;
      end
   end

   assign pin_if.pin_sensed_level = sync2_q;
   assign pin_out_o               = out_q;
   assign pin_oe_o                = oe_q;
   assign pin_pull_dn_o           = pd_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   od_low_only_a: assert property (
      ((pin_out_o | (pin_oe_o ^ ~$past(pin_if.pin_drive_level)))
        & $past(pin_if.pin_drive_open_sel & pin_if.pin_dir_is_output)) == 4'h0)
      else $error("open-drain pin driven high or enable wrong");

   pp_drive_a: assert property (
      (((pin_out_o ^ $past(pin_if.pin_drive_level)) | ~pin_oe_o)
        & $past(~pin_if.pin_drive_open_sel & pin_if.pin_dir_is_output)) == 4'h0)
      else $error("push-pull pin not driving its level");

   input_pull_a: assert property (
      pin_pull_dn_o == ~$past(pin_if.pin_dir_is_output)
      && (pin_oe_o & ~$past(pin_if.pin_dir_is_output)) == 4'h0)
      else $error("input pin driven or pull-down wrong");

   sync_delay_a: assert property (
      $past(rst_n_i, 2) |-> pin_if.pin_sensed_level == $past(pin_in_i, 2))
      else $error("sensed level not two cycles behind the pin");

endmodule : ucgp_pad

//--- rtl/ucgp_port.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module ucgp_port (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // register access from the host interface
   input  wire logic [1:0]  reg_chan_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_rd_i,
   output      logic [7:0]  reg_rdata_o,
   // device pins 15..0
   input  wire logic [15:0] pin_in_i,
   output      logic [15:0] pin_out_o,
   output      logic [15:0] pin_oe_o,
   output      logic [15:0] pin_pull_dn_o,
   // special character merge, one byte per channel
   input  wire logic [3:0]  pin_address_merge_i,
   input  wire logic [31:0] xoff2_char_i,
   output      logic [31:0] merged_char_o
);
   import ucgp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // reset release: asserts at once, leaves on the clock
   logic       rst_s1_q;
   logic       rst_s2_q;
   logic       rst_s1_d;
   logic       rst_s2_d;
   logic       rst_n;

   always_comb begin
      rst_s1_d = 1'b1;
      rst_s2_d = rst_s1_q;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= rst_s1_d;
         rst_s2_q <= rst_s2_d;
      end
   end

   assign rst_n = rst_s2_q;

   ////////////////////////////////////////////////////////////////////////////
   // address decode, shared by the write and read paths
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction : reg_hit

   ////////////////////////////////////////////////////////////////////////////
   // per-channel state
   logic [7:0] cfg_q   [NUM_CHAN];
   logic [7:0] cfg_d   [NUM_CHAN];
   ucgp_nib_t  lvl_q   [NUM_CHAN];
   ucgp_nib_t  lvl_d   [NUM_CHAN];
   ucgp_nib_t  sensed  [NUM_CHAN];
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [31:0] merged_q;
   logic [31:0] merged_d;

   ucgp_pin_if pif [NUM_CHAN] ();

   // channel k's pads sit on device pins 4k..4k+3, local pin n on 4k+n
   for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      assign pif[ch].pin_dir_is_output  = cfg_q[ch][CFG_DIR_LSB +: 4];
      assign pif[ch].pin_drive_open_sel = cfg_q[ch][CFG_OD_LSB +: 4];
      assign pif[ch].pin_drive_level    = lvl_q[ch];
      assign sensed[ch]                 = pif[ch].pin_sensed_level;

      ucgp_pad u_pad (
         .mclk_i        (mclk_i),
         .rst_n_i       (rst_n),
         .pin_if        (pif[ch]),
         .pin_in_i      (pin_in_i[ch*4 +: 4]),
         .pin_out_o     (pin_out_o[ch*4 +: 4]),
         .pin_oe_o      (pin_oe_o[ch*4 +: 4]),
         .pin_pull_dn_o (pin_pull_dn_o[ch*4 +: 4])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes and reads; a read in the same cycle as a write to the
   // same register returns the old value, which keeps the read path short
   always_comb begin
      logic [7:0] rd_word;
      rd_word = RDATA_UNMAPPED;
      for (int ch = 0; ch < NUM_CHAN; ch++) begin
         cfg_d[ch] = cfg_q[ch];
         lvl_d[ch] = lvl_q[ch];
         if (reg_wr_i && reg_chan_i == 2'(ch)) begin
            if (reg_hit(reg_addr_i, ADDR_PIN_CONFIG)) begin
               cfg_d[ch] = reg_wdata_i;
            end
            // sensed bits are read-only, so only the low nibble is stored
            if (reg_hit(reg_addr_i, ADDR_PIN_DATA)) begin
               lvl_d[ch] = reg_wdata_i[DATA_OUT_LSB +: 4];
            end
         end
         // merged byte: upper nibble from the character, lower from pins
         if (pin_address_merge_i[ch]) begin
            merged_d[ch*8 +: 8] = {xoff2_char_i[ch*8 + CHAR_HI_LSB +: 4], sensed[ch]};
         end else begin
            merged_d[ch*8 +: 8] = xoff2_char_i[ch*8 +: 8];
         end
      end
      if (reg_hit(reg_addr_i, ADDR_PIN_CONFIG)) begin
         rd_word = cfg_q[reg_chan_i];
      end else if (reg_hit(reg_addr_i, ADDR_PIN_DATA)) begin
         rd_word[DATA_IN_LSB +: 4]  = sensed[reg_chan_i];
         rd_word[DATA_OUT_LSB +: 4] = lvl_q[reg_chan_i];
      end
      rdata_d = reg_rd_i ? rd_word : rdata_q;
   end

   // register update; all bits zero after reset
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q    <= '{default: PIN_CONFIG_RST};
         lvl_q    <= '{default: PIN_DATA_RST[DATA_OUT_LSB +: 4]};
         rdata_q  <= RDATA_UNMAPPED;
         merged_q <= '0;
      end else begin
         cfg_q    <= cfg_d;
         lvl_q    <= lvl_d;
         rdata_q  <= rdata_d;
         merged_q <= merged_d;
      end
   end

   assign reg_rdata_o   = rdata_q;
   assign merged_char_o = merged_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   sequence wr_cfg0_s;
      reg_wr_i && reg_chan_i == 2'd0 && reg_hit(reg_addr_i, ADDR_PIN_CONFIG);
   endsequence

   sequence cfg_settle_s;
      wr_cfg0_s ##1 !reg_wr_i;
   endsequence

   sequence rd_data1_s;
      reg_rd_i && reg_chan_i == 2'd1 && reg_hit(reg_addr_i, ADDR_PIN_DATA);
   endsequence

   cfg_store_a: assert property (wr_cfg0_s |=> cfg_q[0] == $past(reg_wdata_i))
      else $error("configuration write not stored");

   dir_to_pin_a: assert property (
      cfg_settle_s |=> pin_pull_dn_o[3:0] == ~$past(reg_wdata_i[3:0], 2))
      else $error("direction bits did not reach channel 0 pins");

   od_to_pin_a: assert property (
      cfg_settle_s |=> (pin_out_o[3:0] & $past(reg_wdata_i[7:4], 2)) == 4'h0)
      else $error("open-drain pin of channel 0 driving high");

   data_read_a: assert property (
      rd_data1_s |=> reg_rdata_o == {$past(sensed[1]), $past(lvl_q[1])})
      else $error("data register read wrong");

   unmapped_rd_a: assert property (
      reg_rd_i && !reg_hit(reg_addr_i, ADDR_PIN_CONFIG) && !reg_hit(reg_addr_i, ADDR_PIN_DATA)
      |=> reg_rdata_o == RDATA_UNMAPPED)
      else $error("unmapped read not zero");

   lvl_hold_a: assert property (
      !reg_wr_i |=> lvl_q[2] == $past(lvl_q[2]) && cfg_q[2] == $past(cfg_q[2]))
      else $error("register changed without a write");

   pin_map_a: assert property (
      $past(rst_n) |-> pin_pull_dn_o[15:12] == ~$past(cfg_q[3][3:0]))
      else $error("channel 3 not on pins 15..12");

   merge_on_a: assert property (
      pin_address_merge_i[2]
      |=> merged_char_o[23:16] == {$past(xoff2_char_i[23:20]), $past(sensed[2])})
      else $error("merged character wrong");

   merge_off_a: assert property (
      !pin_address_merge_i[0] |=> merged_char_o[7:0] == $past(xoff2_char_i[7:0]))
      else $error("unmerged character wrong");

   reset_val_a: assert property (
      $rose(rst_n) |-> cfg_q[1] == PIN_CONFIG_RST && lvl_q[1] == 4'h0 && pin_oe_o == 16'h0000)
      else $error("state not zero after reset");

endmodule : ucgp_port

//--- verif/ucgp_pin_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// board around the sixteen pins: a driver, pull-up resistors, floating lines
module ucgp_pin_model (
   // clock for the floating pattern
   input  wire logic        mclk_i,
   // pad controls from the device
   input  wire logic [15:0] pin_out_i,
   input  wire logic [15:0] pin_oe_i,
   input  wire logic [15:0] pin_pull_dn_i,
   // board set-up chosen by the bench
   input  wire logic [15:0] ext_en_i,
   input  wire logic [15:0] ext_lvl_i,
   input  wire logic [15:0] pull_up_i,
   // resolved wire levels
   output      logic [15:0] pin_wire_o
);
   logic [15:0] float_q = 16'h5a5a;

   // a line nobody holds keeps changing, so a stale value never looks right
   always @(posedge mclk_i) begin
      float_q <= ~float_q;
   end

   // device drive wins, then the board driver; a resistor pull-up beats the weak pull-down
   assign pin_wire_o = (pin_oe_i & pin_out_i)
                     | (~pin_oe_i & ext_en_i & ext_lvl_i)
                     | (~pin_oe_i & ~ext_en_i & pull_up_i)
                     | (~pin_oe_i & ~ext_en_i & ~pull_up_i & ~pin_pull_dn_i & float_q);
endmodule : ucgp_pin_model

//--- verif/ucgp_port_test.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the per-channel pin port
module ucgp_port_test;
   import ucgp_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_n_i;
   logic [1:0]  reg_chan_i = 2'h0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_rdata_o;
   logic [15:0] pin_in_i;
   logic [15:0] pin_out_o;
   logic [15:0] pin_oe_o;
   logic [15:0] pin_pull_dn_o;
   logic [3:0]  merge = 4'h0;
   logic [31:0] xoff2 = 32'h0;
   logic [31:0] merged_char_o;
   logic [15:0] ext_en = 16'h0;
   logic [15:0] ext_lvl = 16'h0;
   logic [15:0] pull_up = 16'h0;
   logic [7:0]  cfg[4] = '{default: 8'h00};
   logic [7:0]  dat[4] = '{default: 8'h00};
   logic [7:0]  exp_q[$];
   logic        rd_taken = 1'b0;
   int          num_errors = 0;
   int          checks_done = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and the device with its board
   always #25 mclk_i = ~mclk_i;

   ucgp_port DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_chan_i(reg_chan_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pull_dn_o(pin_pull_dn_o),
      .pin_address_merge_i(merge), .xoff2_char_i(xoff2), .merged_char_o(merged_char_o));

   ucgp_pin_model board (.mclk_i(mclk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
      .pin_pull_dn_i(pin_pull_dn_o), .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pull_up_i(pull_up),
      .pin_wire_o(pin_in_i));

   ////////////////////////////////////////////////////////////////////////////////
   // compare, verdict and bus cycles
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         num_errors++;
      end
   endtask : check

   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run

   task wr(input logic [1:0] ch, input logic [7:0] addr, input logic [7:0] wd);
      @(posedge mclk_i);
      reg_chan_i <= ch;
      reg_addr_i <= addr;
      reg_wdata_i <= wd;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   task rd(input logic [1:0] ch, input logic [7:0] addr, input logic [7:0] exp);
      @(posedge mclk_i);
      reg_chan_i <= ch;
      reg_addr_i <= addr;
      reg_rd_i <= 1'b1;
      exp_q.push_back(exp);
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
   endtask : rd

   // read data shows one edge after the read is taken; the oldest note is its answer
   always @(posedge mclk_i) begin
      if (rd_taken === 1'b1) begin
         if (exp_q.size() == 0)
            check(32'hdead, 32'h0);
         else
            check(reg_rdata_o, exp_q.pop_front());
      end
      rd_taken <= reg_rd_i;
   end

   // pins and merged bytes against what the settings and the board imply
   task check_pins;
      logic [15:0] oe, out, pd, wire_lvl;
      logic [31:0] mc;
      oe = '0;
      out = '0;
      pd = '0;
      for (int p = 0; p < 16; p++) begin
         oe[p] = cfg[p/4][p%4] & (~cfg[p/4][4+p%4] | ~dat[p/4][p%4]);
         // the level register reaches the pad output whenever the pin is push-pull;
         // the enable alone decides whether the pin is actually driven
         out[p] = ~cfg[p/4][4+p%4] & dat[p/4][p%4];
         pd[p] = ~cfg[p/4][p%4];
      end
      wire_lvl = (oe & out) | (~oe & ext_en & ext_lvl) | (~oe & ~ext_en & pull_up);
      for (int k = 0; k < 4; k++)
         mc[8*k +: 8] = merge[k] ? {xoff2[8*k+4 +: 4], wire_lvl[4*k +: 4]} : xoff2[8*k +: 8];
      @(negedge mclk_i);
      check(pin_oe_o, oe);
      check(pin_out_o, out);
      check(pin_pull_dn_o, pd);
      check(merged_char_o, mc);
      for (int k = 0; k < 4; k++) begin
         rd(k[1:0], ADDR_PIN_CONFIG, cfg[k]);
         rd(k[1:0], ADDR_PIN_DATA, {wire_lvl[4*k +: 4], dat[k][3:0]});
      end
   endtask : check_pins

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset, defaults, refusals, random configurations
   initial begin
      logic [7:0] w;
      // reset goes low in the first update pass, so the asynchronous flops see a real edge
      rst_n_i <= 1'b0;
      void'($urandom(93898));
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      check_pins();
      $display("test reset values done");
      wr(2'h0, 8'h1a, 8'hff);
      rd(2'h0, 8'h1a, RDATA_UNMAPPED);
      rd(2'h0, ADDR_PIN_CONFIG, 8'h00);
      $display("test unmapped access done");
      for (int it = 0; it < 10; it++) begin
         for (int k = 0; k < 4; k++) begin
            cfg[k] = 8'($urandom);
            w = 8'($urandom);
            dat[k] = {4'h0, w[3:0]};
            wr(k[1:0], ADDR_PIN_CONFIG, cfg[k]);
            wr(k[1:0], ADDR_PIN_DATA, w);
         end
         @(posedge mclk_i);
         for (int p = 0; p < 16; p++) begin
            ext_en[p] <= ~cfg[p/4][p%4] & 1'($urandom);
            pull_up[p] <= cfg[p/4][4+p%4] | 1'($urandom);
         end
         ext_lvl <= 16'($urandom);
         merge <= 4'($urandom);
         xoff2 <= $urandom;
         repeat (4) @(posedge mclk_i);
         check_pins();
         $display("test random pins %0d done", it);
      end
      // reset in mid-run with non-zero registers: register bits must fall back to zero, the pad pull-downs to one
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      cfg = '{default: 8'h00};
      dat = '{default: 8'h00};
      // internal reset leaves two edges later, then the synchroniser needs two more
      repeat (5) @(posedge mclk_i);
      check_pins();
      $display("test reset in mid-run done");
      for (int i = 0; i < 10 && exp_q.size() > 0; i++)
         @(posedge mclk_i);
      if (exp_q.size() > 0)
         num_errors++;
      complete_run();
   end
endmodule : ucgp_port_test
